// >>> hw/tach_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: pclk at 100 MHz
// Notes: included by bare name
`ifndef TACH_CFG_SVH
`define TACH_CFG_SVH
`define OFS_CONTROL 4'h0
`define OFS_STATUS 4'h4
`define OFS_UPPER 4'h8
`define OFS_LOWER 4'hc
`define CTL_ENABLE_BIT 1
`define CTL_FILTER_BIT 8
`define CTL_MODE_BIT 10
`define CTL_EDGES_LO 11
`define CTL_EDGES_HI 12
`define CTL_RDY_IE_BIT 14
`define CTL_TOG_IE_BIT 15
`define CTL_COUNT_LO 16
`define CTL_COUNT_HI 31
`define STS_LIMIT_BIT 0
`define STS_TOGGLE_BIT 1
`define STS_READY_BIT 2
`define STS_FLAGS 3
`define UPPER_RESET 16'hffff
`define LOWER_RESET 16'h0000
`define COUNT_MAX 16'hffff
`define EDGES_SEL0 4'h2
`define EDGES_SEL1 4'h3
`define EDGES_SEL2 4'h5
`define EDGES_SEL3 4'h9
`define PCLK_PERIOD_NS 10
`define TICK_PERIOD_NS 10000
`define TICK_CYCLES (`TICK_PERIOD_NS / `PCLK_PERIOD_NS)
`define FILTER_TICKS 2'h2
`endif

// >>> hw/tach_pkg.sv
// Purpose: shared types of the fan speed monitor
// Assumes: nothing
// Notes: constants live in tach_cfg.svh
package tach_pkg;
  typedef logic [15:0] count_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;
endpackage

// >>> hw/tach_link_if.sv
// Purpose: signals between the monitor core and its helpers
// Assumes: all on pclk
// Notes: no clocking block
`timescale 1ns/10ps
`default_nettype none
interface tach_link_if;
  import tach_pkg::*;
  logic tick;
  logic filter_en;
  logic pulse_edge;
  logic pulse_rise;
  count_t reading;
  count_t upper;
  count_t lower;
  logic out_of_range;
  modport cond (input tick, input filter_en,
    output pulse_edge, output pulse_rise);
  modport cmp (input reading, input upper, input lower,
    output out_of_range);
  modport core (output tick, output filter_en, output reading,
    output upper, output lower, input pulse_edge, input pulse_rise,
    input out_of_range);
endinterface
`default_nettype wire

// >>> hw/pulse_conditioner.sv
// Purpose: synchronise, filter and edge-detect the fan pulse pin
// Assumes: tick is a one-cycle strobe at 100 kHz
// Notes: edges come out one cycle after acceptance
`timescale 1ns/10ps
`default_nettype none
`include "tach_cfg.svh"
module pulse_conditioner
  import tach_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fan pin
  input wire logic fan_pulse,
  // to core
  tach_link_if.cond link
);
  logic sync_a, sync_b, level;
  logic [1:0] hold;
  logic [1:0] next_hold;
  wire differs = sync_b != level;
  wire hold_done = link.tick && (hold == `FILTER_TICKS - 2'h1);
  wire accept = link.filter_en ? (differs && hold_done) : differs;
  assign next_hold = !differs ? 2'h0 :
    (link.tick && hold != 2'h3) ? hold + 2'h1 : hold;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      level <= 1'b0;
      hold <= 2'h0;
      link.pulse_edge <= 1'b0;
      link.pulse_rise <= 1'b0;
    end else begin
      sync_a <= fan_pulse;
      sync_b <= sync_a;
      hold <= accept ? 2'h0 : next_hold;
      level <= accept ? sync_b : level;
      link.pulse_edge <= accept;
      link.pulse_rise <= accept && sync_b;
    end
  end
endmodule
`default_nettype wire

// >>> hw/range_checker.sv
// Purpose: compare the latched reading with the two bounds
// Assumes: bounds are unsigned 16-bit
// Notes: result is registered, one cycle behind the reading
`timescale 1ns/10ps
`default_nettype none
module range_checker
  import tach_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // from core
  tach_link_if.cmp link
);
  wire above = link.reading > link.upper;
  wire below = link.reading < link.lower;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.out_of_range <= 1'b0;
    end else begin
      link.out_of_range <= above || below;
    end
  end
endmodule
`default_nettype wire

// >>> hw/tach_monitor.sv
// Purpose: fan speed monitor with apb register slave
// Assumes: pclk 100 MHz, sleep_req synchronous to pclk
// Notes: apb answers with one wait state
// Operation
// - 100 kHz tick derived, counts ticks
// - reset returns everything to defaults
// - interrupt is or of status events
// - free mode counts fan rising edges
// - free counter wraps ffff to zero
// - free mode copies every increment out
// - reading count has no side effect
// - clock mode counts ticks over edges
// - edges seen: latch count, set ready
// - ready flag plus enable raises interrupt
// - clock mode latches at ffff too
// - clock mode clears counter after copy
// - ffff reading trips limit below ffff
// - reading outside bounds sets limit flag
// - limit flag always raises interrupt
// - count field 16 bits, read-only, top
// - free counting only while enabled
// - low-power request stops the block
// - registers at 00, 04, 08, 0c
// - edge select 2, 3, 5, 9
// - mode bit one selects clock mode
// - filter drops pulses that span fewer than two tick strobes
`timescale 1ns/10ps
`default_nettype none
`include "tach_cfg.svh"
module tach_monitor
  import tach_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fan pin
  input wire logic fan_pulse,
  // power unit
  input wire logic sleep_req,
  output logic sleep_ack,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  tach_link_if link ();

  pulse_conditioner u_cond (
    .pclk(pclk),
    .presetn(presetn),
    .fan_pulse(fan_pulse),
    .link(link.cond)
  );

  range_checker u_range (
    .pclk(pclk),
    .presetn(presetn),
    .link(link.cmp)
  );

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  logic [9:0] tick_div;
  logic tick;
  logic block_enable, filter_enable, mode_clock;
  logic [1:0] edge_sel;
  logic ready_ie, toggle_ie;
  count_t count_value, pulse_count, upper, lower;
  logic [3:0] edge_seen;
  logic [`STS_FLAGS-1:0] flags;
  bus_state_t bus_state;

  assign link.tick = tick;
  assign link.filter_en = filter_enable;
  assign link.reading = count_value;
  assign link.upper = upper;
  assign link.lower = lower;

  // ----------------------------------------------------------
  // tick divider
  // ----------------------------------------------------------
  // divider halts in sleep so no tick reaches the counter
  wire div_wrap = tick_div == 10'(`TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 10'h000;
      tick <= 1'b0;
    end else begin
      tick_div <= (sleep_ack || div_wrap) ? 10'h000 : tick_div + 10'h001;
      tick <= !sleep_ack && div_wrap;
    end
  end

  // ----------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------
  // offset decode
  wire hi_zero = paddr[11:4] == 8'h00;
  wire sel_ctrl = hi_zero && paddr[3:0] == `OFS_CONTROL;
  wire sel_stat = hi_zero && paddr[3:0] == `OFS_STATUS;
  wire sel_upper = hi_zero && paddr[3:0] == `OFS_UPPER;
  wire sel_lower = hi_zero && paddr[3:0] == `OFS_LOWER;
  wire bad_addr = !(sel_ctrl || sel_stat || sel_upper || sel_lower);
  wire bus_take = psel && penable && bus_state == BUS_IDLE;
  wire bus_fire = psel && penable && bus_state == BUS_DONE;
  wire wr_ok = bus_fire && pwrite && !bad_addr;
  wire wr_ctrl = wr_ok && sel_ctrl;
  wire wr_stat = wr_ok && sel_stat;
  wire wr_upper = wr_ok && sel_upper;
  wire wr_lower = wr_ok && sel_lower;

  wire [31:0] ctrl_word = {count_value, toggle_ie, ready_ie, 1'b0,
    edge_sel, mode_clock, 1'b0, filter_enable, 6'h00, block_enable, 1'b0};
  wire [31:0] stat_word = {29'h0000_0000, flags};
  wire [31:0] rd_data = sel_ctrl ? ctrl_word :
    sel_stat ? stat_word :
    sel_upper ? {16'h0000, upper} :
    sel_lower ? {16'h0000, lower} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (bus_take) begin
            bus_state <= BUS_DONE;
            pready <= 1'b1;
            pslverr <= bad_addr;
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
          end
        end
        BUS_DONE: begin
          bus_state <= BUS_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          bus_state <= BUS_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------
  // defaults on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_enable <= 1'b0;
      filter_enable <= 1'b0;
      mode_clock <= 1'b0;
      edge_sel <= 2'h0;
      ready_ie <= 1'b0;
      toggle_ie <= 1'b0;
      upper <= `UPPER_RESET;
      lower <= `LOWER_RESET;
    end else begin
      if (wr_ctrl) begin
        block_enable <= pwdata[`CTL_ENABLE_BIT];
        filter_enable <= pwdata[`CTL_FILTER_BIT];
        mode_clock <= pwdata[`CTL_MODE_BIT];
        edge_sel <= pwdata[`CTL_EDGES_HI:`CTL_EDGES_LO];
        ready_ie <= pwdata[`CTL_RDY_IE_BIT];
        toggle_ie <= pwdata[`CTL_TOG_IE_BIT];
      end
      if (wr_upper) begin
        upper <= pwdata[15:0];
      end
      if (wr_lower) begin
        lower <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------
  // counter
  // ----------------------------------------------------------
  // sleep gates all counting
  wire active = block_enable && !sleep_ack;
  wire free_inc = active && !mode_clock && link.pulse_rise;
  wire clk_run = active && mode_clock;
  wire [3:0] edge_target = edge_sel == 2'h0 ? `EDGES_SEL0 :
    edge_sel == 2'h1 ? `EDGES_SEL1 :
    edge_sel == 2'h2 ? `EDGES_SEL2 : `EDGES_SEL3;
  wire clk_edge = clk_run && link.pulse_edge;
  wire first_edge = clk_edge && edge_seen == 4'h0;
  wire edges_done = clk_edge && !first_edge &&
    (edge_seen + 4'h1 == edge_target);
  wire at_max = clk_run && !clk_edge && pulse_count == `COUNT_MAX;
  wire free_next_zero = pulse_count == `COUNT_MAX;
  count_t next_pulse_count;
  assign next_pulse_count = pulse_count + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_count <= 16'h0000;
      count_value <= 16'h0000;
      edge_seen <= 4'h0;
    end else if (free_inc) begin
      pulse_count <= next_pulse_count;
      count_value <= next_pulse_count;
    end else if (edges_done || at_max) begin
      count_value <= pulse_count;
      pulse_count <= 16'h0000;
      edge_seen <= edges_done ? 4'h1 : 4'h0;
    end else if (first_edge) begin
      pulse_count <= 16'h0000;
      edge_seen <= 4'h1;
    end else if (clk_edge) begin
      edge_seen <= edge_seen + 4'h1;
    end else if (clk_run && tick) begin
      pulse_count <= next_pulse_count;
    end
  end

  // ----------------------------------------------------------
  // status flags and interrupt
  // ----------------------------------------------------------
  wire [`STS_FLAGS-1:0] flag_set;
  assign flag_set[`STS_LIMIT_BIT] = link.out_of_range;
  assign flag_set[`STS_TOGGLE_BIT] = active && link.pulse_edge;
  assign flag_set[`STS_READY_BIT] = edges_done;

  logic [`STS_FLAGS-1:0] next_flags;
  genvar g;
  generate
    for (g = 0; g < `STS_FLAGS; g = g + 1) begin : g_flag
      // set beats a simultaneous write-one clear
      assign next_flags[g] = flag_set[g] ||
        (flags[g] && !(wr_stat && pwdata[g]));
    end
  endgenerate

  // one process owns the whole flag vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= {`STS_FLAGS{1'b0}};
    end else begin
      flags <= next_flags;
    end
  end

  wire irq_next = flags[`STS_LIMIT_BIT] ||
    (flags[`STS_READY_BIT] && ready_ie) ||
    (flags[`STS_TOGGLE_BIT] && toggle_ie);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      sleep_ack <= 1'b0;
    end else begin
      irq <= irq_next;
      sleep_ack <= sleep_req;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // sleep zeroes the gap and a tick restarts it at one, so the gap
  // reads one full period at every tick, the first one included
  logic [10:0] tick_gap;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_gap <= 11'h000;
    end else begin
      tick_gap <= sleep_ack ? 11'h000 : tick ? 11'h001 : tick_gap + 11'h001;
    end
  end

  property p_tick_period;
    tick_gap <= 11'(`TICK_CYCLES) &&
      (!tick || tick_gap == 11'(`TICK_CYCLES));
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick spacing wrong");

  property p_irq_or;
    ##1 irq == $past(irq_next);
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("irq not or of flags");

  property p_free_wrap;
    free_inc && free_next_zero |=> pulse_count == 16'h0000
      && count_value == 16'h0000;
  endproperty
  a_free_wrap: assert property (p_free_wrap)
    else $error("free counter did not wrap");

  property p_free_copy;
    free_inc |=> count_value == pulse_count &&
      pulse_count == $past(pulse_count) + 16'h0001;
  endproperty
  a_free_copy: assert property (p_free_copy)
    else $error("free count not copied");

  property p_read_quiet;
    bus_fire && !pwrite && sel_ctrl && !mode_clock && !free_inc |=>
      $stable(pulse_count) && $stable(count_value);
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("read disturbed counter");

  sequence s_latch;
    edges_done ##1 count_value == $past(pulse_count);
  endsequence
  property p_ready_latch;
    edges_done |-> s_latch ##0 (flags[`STS_READY_BIT] &&
      pulse_count == 16'h0000);
  endproperty
  a_ready_latch: assert property (p_ready_latch)
    else $error("edge latch missed");

  property p_max_latch;
    at_max |=> count_value == `COUNT_MAX && pulse_count == 16'h0000;
  endproperty
  a_max_latch: assert property (p_max_latch)
    else $error("saturation latch missed");

  sequence s_over;
    (count_value > upper)[*2];
  endsequence
  property p_limit;
    s_over |=> flags[`STS_LIMIT_BIT] ##1 irq;
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit flag or irq missed");

  property p_disabled_hold;
    !block_enable && !mode_clock |=> $stable(pulse_count);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("count moved while disabled");

  property p_sleep;
    sleep_req ##1 sleep_ack |=> $stable(pulse_count) && !tick;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("block ran in sleep");
endmodule
`default_nettype wire

// >>> verif/fan_model.sv
// Purpose: fan tachometer pin model for the speed monitor bench
// Assumes: driven from the bench through its tasks and spin flag
// Notes: edges are launched just after a pclk rising edge
`timescale 1ns/10ps
`default_nettype none
module fan_model #(
  parameter int HALF = 2000
) (
  // clock
  input wire logic pclk,
  // fan pin
  output logic fan_pulse
);
  bit spin;

  initial begin
    fan_pulse = 1'b0;
    spin = 1'b0;
  end

  // ----------------------------------------
  // square wave at a fixed half period
  // ----------------------------------------
  always begin
    @(posedge pclk);
    if (spin) begin
      repeat (HALF - 1) @(posedge pclk);
      fan_pulse <= ~fan_pulse;
    end
  end

  // n whole periods, h cycles low then h high
  task pulses(input int n, input int h);
    repeat (n) begin
      repeat (h) @(posedge pclk);
      fan_pulse <= 1'b1;
      repeat (h) @(posedge pclk);
      fan_pulse <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/tach_monitor_tb_top.sv
// Purpose: self-checking bench of the fan speed monitor
// Assumes: apb answers with one wait state, tick every 1000 pclk
// Notes: saturation at ffff needs 655 ms and is not run here
`timescale 1ns/10ps
`default_nettype none
`include "tach_cfg.svh"
module tach_monitor_tb_top;
  localparam int HALF = 2000;
  localparam logic [11:0] A_CTL = 12'h000;
  localparam logic [11:0] A_STS = 12'h004;
  localparam logic [11:0] A_UP = 12'h008;
  localparam logic [11:0] A_LO = 12'h00c;
  localparam logic [31:0] EN = 32'h1 << `CTL_ENABLE_BIT;
  localparam logic [31:0] FLT = 32'h1 << `CTL_FILTER_BIT;
  localparam logic [31:0] MODE = 32'h1 << `CTL_MODE_BIT;
  localparam logic [31:0] RIE = 32'h1 << `CTL_RDY_IE_BIT;
  localparam logic [31:0] TIE = 32'h1 << `CTL_TOG_IE_BIT;
  logic pclk, presetn, psel, penable, pwrite, sleep_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, sleep_ack, irq, fan_pulse, ev;
  int mismatches, n_tests;

  tach_monitor tach_monitor_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fan_pulse,
    .sleep_req, .sleep_ack, .irq);
  fan_model #(.HALF(HALF)) fan_model_i (.pclk, .fan_pulse);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp,
           input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      mismatches++;
      close_out();
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rchk(input string what, input logic [11:0] a,
            input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rv);
  endtask

  task cchk(input string what, input logic [15:0] exp);
    apb(1'b0, A_CTL, 32'h0);
    chk(what, {16'h0, exp}, {16'h0, rv[31:16]});
  endtask

  task fchk(input string what, input int b, input logic exp);
    apb(1'b0, A_STS, 32'h0);
    chk(what, {31'h0, exp}, {31'h0, rv[b]});
  endtask

  task wait_ready;
    int k;
    for (k = 0; k < 300; k++) begin
      apb(1'b0, A_STS, 32'h0);
      if (rv[`STS_READY_BIT] === 1'b1)
        return;
      repeat (200) @(posedge pclk);
    end
    mismatches++;
    close_out();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_defaults;
    rchk("control", A_CTL, 32'h0);
    rchk("status", A_STS, 32'h0);
    rchk("upper", A_UP, 32'h0000ffff);
    rchk("lower", A_LO, 32'h0);
    rchk("unmapped", 12'h010, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, ev});
    wr(A_CTL, 32'hffff0000);
    cchk("count_ro", 16'h0);
    $display("test defaults done");
  endtask

  task t_free;
    // short bursts, read long before the count could wrap
    wr(A_CTL, EN);
    fan_model_i.pulses(5, 50);
    repeat (8) @(posedge pclk);
    cchk("free_count", 16'h5);
    cchk("reread", 16'h5);
    // stop the block while the fan keeps pulsing
    wr(A_CTL, 32'h0);
    fan_model_i.pulses(3, 50);
    cchk("disabled", 16'h5);
    wr(A_CTL, EN);
    sleep_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("sleep_ack", 32'h1, {31'h0, sleep_ack});
    fan_model_i.pulses(3, 50);
    cchk("asleep", 16'h5);
    sleep_req <= 1'b0;
    fan_model_i.pulses(1, 50);
    repeat (8) @(posedge pclk);
    cchk("woken", 16'h6);
    $display("test free done");
  endtask

  task t_irq;
    fchk("toggle_flag", `STS_TOGGLE_BIT, 1'b1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(A_CTL, EN | TIE);
    repeat (3) @(posedge pclk);
    chk("irq_toggle", 32'h1, {31'h0, irq});
    wr(A_STS, 32'h7);
    repeat (3) @(posedge pclk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    // filter on drops a 500-cycle pulse, filter off counts it
    wr(A_CTL, EN | FLT);
    fan_model_i.pulses(1, 500);
    repeat (2500) @(posedge pclk);
    cchk("glitch_dropped", 16'h6);
    wr(A_CTL, EN);
    fan_model_i.pulses(1, 500);
    repeat (8) @(posedge pclk);
    cchk("glitch_kept", 16'h7);
    $display("test irq and filter done");
  endtask

  task t_limit;
    wr(A_UP, 32'h6);
    fchk("limit_high", `STS_LIMIT_BIT, 1'b1);
    chk("irq_limit", 32'h1, {31'h0, irq});
    wr(A_UP, 32'h0000ffff);
    wr(A_STS, 32'h7);
    fchk("limit_gone", `STS_LIMIT_BIT, 1'b0);
    wr(A_LO, 32'h8);
    fchk("limit_low", `STS_LIMIT_BIT, 1'b1);
    wr(A_LO, 32'h0);
    wr(A_STS, 32'h7);
    $display("test limit done");
  endtask

  task t_clock(input int s);
    int n, lo, hi;
    logic inb;
    n = s == 0 ? `EDGES_SEL0 : s == 1 ? `EDGES_SEL1 :
        s == 2 ? `EDGES_SEL2 : `EDGES_SEL3;
    // window runs from n-1 to n half periods of the wave, in ticks
    lo = (n - 1) * HALF / `TICK_CYCLES - 1;
    hi = n * HALF / `TICK_CYCLES + 1;
    wr(A_CTL, EN | MODE | RIE | (32'(s) << `CTL_EDGES_LO));
    fan_model_i.spin <= 1'b1;
    wait_ready;
    wr(A_STS, 32'h7);
    wait_ready;
    chk("irq_ready", 32'h1, {31'h0, irq});
    apb(1'b0, A_CTL, 32'h0);
    inb = rv[31:16] >= lo && rv[31:16] <= hi;
    chk("tick_window", 32'h1, {31'h0, inb});
    fan_model_i.spin <= 1'b0;
    wr(A_CTL, 32'h0);
    wr(A_STS, 32'h7);
    $display("test clock sel %0d done", s);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    sleep_req = 1'b0;
    mismatches = 0;
    n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_free();
    t_irq();
    t_limit();
    // sel 2 is the five-edge setting for two-period fans
    for (int s = 0; s < 4; s++)
      t_clock(s);
    fan_model_i.spin <= 1'b1;
    wr(A_CTL, EN | MODE);
    repeat (3000) @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    fan_model_i.spin <= 1'b0;
    t_defaults();
    close_out();
  end
endmodule
`default_nettype wire
